// ===== rtl/eeprom_cache_pkg.sv
// constants and carrier types for the page cache writer
// assumes a 200 MHz mclk; shared by the writer and its output buffer
package eeprom_cache_pkg;
	// timing
	localparam int unsigned CLK_PERIOD_NS     = 5;
	localparam int unsigned WRITE_TIME_NS     = 5_000_000;
	localparam int unsigned WRITE_CYCLES_DFLT = WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int          TIMER_W           = 20;

	// cache geometry
	localparam int PAGE_BYTES  = 8;
	localparam int CACHE_BYTES = 64;

	// decode values and reset values
	localparam logic [3:0]         DEV_TYPE_CODE = 4'ha;
	localparam logic [2:0]         BIT_LAST      = 3'h7;
	localparam logic [2:0]         PAGE_FIRST    = 3'h0;
	localparam logic [2:0]         PAGE_LAST     = 3'h7;
	localparam logic [5:0]         PTR_RESET     = 6'h00;
	localparam logic [3:0]         ADDR_HI_RESET = 4'h0;
	localparam logic [8:0]         PAGE_RESET    = 9'h000;
	localparam logic [63:0]        VALID_RESET   = 64'h0000_0000_0000_0000;
	localparam logic [TIMER_W-1:0] TIMER_RESET   = 20'h0_0000;
	localparam logic [TIMER_W-1:0] TIMER_ONE     = 20'h0_0001;

	// one page program request toward the array
	typedef struct packed {
		logic [8:0]  page;
		logic [7:0]  mask;
		logic [63:0] data;
	} page_write_type;

	// asynchronous pins, synchronised together
	typedef struct packed {
		logic       scl;
		logic       sda;
		logic [2:0] cs;
		logic       low_volt;
	} pin_in_type;
endpackage

// ===== rtl/page_word_buffer.sv
// two-entry buffer for page program requests
// assumes both sides on mclk; outputs come straight from flops
`timescale 1ns/1ps
module page_word_buffer
	import eeprom_cache_pkg::*;
(
	// clock, reset, enable
	input  wire logic           mclk,
	input  wire logic           rstn,
	input  wire logic           ce,
	// filling side
	input  wire logic           in_valid,
	output      logic           in_ready,
	input  wire page_write_type in_word,
	// draining side
	output      logic           out_valid,
	input  wire logic           out_ready,
	output      page_write_type out_word
);
	logic           head_v_reg;
	logic           tail_v_reg;
	page_write_type tail_reg;
	wire            push = in_valid & ~tail_v_reg;
	wire            pop  = head_v_reg & out_ready;

	assign in_ready  = ~tail_v_reg;
	assign out_valid = head_v_reg;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			head_v_reg <= 1'b0;
			tail_v_reg <= 1'b0;
			out_word   <= '0;
			tail_reg   <= '0;
		end else if (ce) begin
			if (pop && tail_v_reg) begin
				out_word   <= tail_reg;
				tail_v_reg <= push;
				tail_reg   <= in_word;
			end else if (pop || (push && !head_v_reg)) begin
				out_word   <= in_word;
				head_v_reg <= push;
			end else if (push) begin
				tail_reg   <= in_word;
				tail_v_reg <= 1'b1;
			end
		end
	end
endmodule

// ===== rtl/eeprom_page_cache_writer.sv
// two-wire write front end, 64-byte page cache and page commit sequencer
// assumes scl, sda, chip selects and low-voltage flag are asynchronous pins
// Overview of operation
// - first data byte of every write command goes into cache page 0
// - load starts at byte offset given by the word address low three bits
// - with nonzero start offset, late bytes wrap into empty leading bytes of page 0
// - bytes beyond cache size keep being accepted, overwriting in load order
// - on STOP, cache page 0 goes to the array page of the start address
// - further loaded cache pages go to consecutive ascending array pages
// - one separate timed write cycle per transferred cache page
// - partly loaded page programs only the loaded byte positions
// - standby once STOP seen and all internal activity has finished
// - aborted transactions also return the device to standby
// - array programming blocked while the supply monitor reports low voltage
// - supply monitor off in standby, on when leaving standby
// - respond only when control byte chip-select bits match the pins
// - SDA is driven low or released, never driven high
// - transmitter changes SDA only while SCL is low
// - SDA change while SCL high is START or STOP and decoded so
// - cache is eight pages of eight bytes, 3-bit page and byte index
// - no acknowledge for the device address during a write cycle
// - each page cycle has the same fixed length, partial or full
// - write sequence starts only on STOP after write data, never on START
`timescale 1ns/1ps
module eeprom_page_cache_writer
	import eeprom_cache_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DFLT
) (
	// clock, reset, enable
	input  wire logic           mclk,
	input  wire logic           rstn,
	input  wire logic           ce,
	// two-wire bus pins
	input  wire logic           scl_in,
	input  wire logic           sda_in,
	output      logic           sda_out,
	output      logic           sda_oe,
	input  wire logic [2:0]     chip_select_inputs,
	// supply monitor
	input  wire logic           low_voltage,
	output      logic           vmon_en,
	// array program port
	output      logic           array_valid,
	input  wire logic           array_ready,
	output      page_write_type array_word,
	// status
	output      logic           busy,
	output      logic           standby
);
	typedef enum logic [2:0] {B_IDLE, B_CTRL, B_ADDR_HI, B_ADDR_LO, B_DATA} bus_state_type;
	typedef enum logic [2:0] {C_IDLE, C_SCAN, C_PUSH, C_WAIT, C_DONE} commit_state_type;

	function automatic logic [7:0] page_mask(input logic [63:0] v, input logic [2:0] k);
		return v[{k, 3'b000} +: 8];
	endfunction

	pin_in_type       pins_m_reg;
	pin_in_type       pins_s_reg;
	logic             scl_d_reg;
	logic             sda_d_reg;
	bus_state_type    bus_state_reg;
	bus_state_type    bus_state_next;
	logic [2:0]       bit_cnt_reg;
	logic [7:0]       shift_reg;
	logic             byte_ready_reg;
	logic             sda_oe_reg;
	logic             sda_out_reg;
	logic [3:0]       addr_hi_reg;
	logic [8:0]       start_page_reg;
	logic [5:0]       load_ptr_reg;
	logic             data_seen_reg;
	logic [63:0]      valid_reg;
	logic [7:0]       cache_mem [CACHE_BYTES];
	commit_state_type commit_state_reg;
	commit_state_type commit_state_next;
	logic [2:0]       page_k_reg;
	logic [TIMER_W-1:0] timer_reg;
	logic             busy_reg;
	logic             standby_reg;
	logic             vmon_en_reg;
	logic [63:0]      page_data;
	logic             buf_in_ready;
	page_write_type   buf_in_word;

	// bus event decode on synchronised levels
	wire scl_s      = pins_s_reg.scl;
	wire sda_s      = pins_s_reg.sda;
	wire scl_rise   = scl_s & ~scl_d_reg;
	wire scl_fall   = ~scl_s & scl_d_reg;
	wire start_det  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_det   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	wire bus_active = bus_state_reg != B_IDLE;
	wire bit_take   = scl_rise & ~sda_oe_reg & ~byte_ready_reg & bus_active;
	wire byte_end   = scl_fall & byte_ready_reg;
	wire ack_end    = scl_fall & sda_oe_reg;
	wire ctrl_match = (shift_reg[7:4] == DEV_TYPE_CODE) && (shift_reg[3:1] == pins_s_reg.cs)
		&& !shift_reg[0] && !busy_reg;
	wire ack_ok       = (bus_state_reg == B_CTRL) ? ctrl_match : 1'b1;
	wire addr_hi_take = byte_end & (bus_state_reg == B_ADDR_HI);
	wire addr_lo_take = byte_end & (bus_state_reg == B_ADDR_LO);
	wire data_take    = byte_end & (bus_state_reg == B_DATA);
	wire commit_go    = stop_det & data_seen_reg & ~busy_reg;

	// commit decode
	wire [7:0] cur_mask    = page_mask(valid_reg, page_k_reg);
	wire       page_loaded = |cur_mask;
	wire       page_last   = page_k_reg == PAGE_LAST;
	wire       prog_block  = pins_s_reg.low_volt;
	wire       push        = (commit_state_reg == C_PUSH) & buf_in_ready & ~prog_block;
	wire       timer_done  = timer_reg == TIMER_ONE;
	wire       page_step   = ((commit_state_reg == C_SCAN) & ~page_loaded & ~page_last)
		| ((commit_state_reg == C_WAIT) & timer_done & ~page_last);
	wire       standby_next = (bus_state_next == B_IDLE) & (commit_state_next == C_IDLE);

	assign sda_oe  = sda_oe_reg;
	assign sda_out = sda_out_reg;
	assign busy    = busy_reg;
	assign standby = standby_reg;
	assign vmon_en = vmon_en_reg;

	// two-flop synchronisers for all pins
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pins_m_reg <= '1;
			pins_s_reg <= '1;
			scl_d_reg  <= 1'b1;
			sda_d_reg  <= 1'b1;
		end else if (ce) begin
			pins_m_reg <= {scl_in, sda_in, chip_select_inputs, low_voltage};
			pins_s_reg <= pins_m_reg;
			scl_d_reg  <= pins_s_reg.scl;
			sda_d_reg  <= pins_s_reg.sda;
		end
	end

	always_comb begin
		bus_state_next = bus_state_reg;
		if (start_det) begin
			bus_state_next = B_CTRL;
		end else if (stop_det) begin
			bus_state_next = B_IDLE;
		end else if (byte_end) begin
			if (!ack_ok) begin
				bus_state_next = B_IDLE;
			end else begin
				unique case (bus_state_reg)
					B_CTRL:    bus_state_next = B_ADDR_HI;
					B_ADDR_HI: bus_state_next = B_ADDR_LO;
					B_ADDR_LO: bus_state_next = B_DATA;
					B_DATA:    bus_state_next = B_DATA;
					B_IDLE:    bus_state_next = B_IDLE;
				endcase
			end
		end
	end

	// bit and byte framing
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bus_state_reg  <= B_IDLE;
			bit_cnt_reg    <= 3'h0;
			shift_reg      <= 8'h00;
			byte_ready_reg <= 1'b0;
		end else if (ce) begin
			bus_state_reg <= bus_state_next;
			if (start_det || stop_det) begin
				bit_cnt_reg    <= 3'h0;
				byte_ready_reg <= 1'b0;
			end else if (bit_take) begin
				shift_reg      <= {shift_reg[6:0], sda_s};
				bit_cnt_reg    <= bit_cnt_reg + 3'h1;
				byte_ready_reg <= bit_cnt_reg == BIT_LAST;
			end else if (byte_end) begin
				byte_ready_reg <= 1'b0;
			end
		end
	end

	// acknowledge drive, changed only after a falling scl
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sda_oe_reg  <= 1'b0;
			sda_out_reg <= 1'b0;
		end else if (ce) begin
			if (start_det || stop_det || ack_end) begin
				sda_oe_reg <= 1'b0;
			end else if (byte_end && ack_ok) begin
				sda_oe_reg <= 1'b1;
			end
		end
	end

	// address capture, load pointer and valid flags
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			addr_hi_reg    <= ADDR_HI_RESET;
			start_page_reg <= PAGE_RESET;
			load_ptr_reg   <= PTR_RESET;
			data_seen_reg  <= 1'b0;
			valid_reg      <= VALID_RESET;
		end else if (ce) begin
			if (addr_hi_take) begin
				addr_hi_reg <= shift_reg[3:0];
			end
			if (addr_lo_take) begin
				start_page_reg <= {addr_hi_reg, shift_reg[7:3]};
				load_ptr_reg   <= {PAGE_FIRST, shift_reg[2:0]};
			end
			if (data_take) begin
				load_ptr_reg           <= load_ptr_reg + 6'h01;
				valid_reg[load_ptr_reg] <= 1'b1;
				data_seen_reg          <= 1'b1;
			end
			if (commit_go) begin
				data_seen_reg <= 1'b0;
			end
			if (push) begin
				valid_reg[{page_k_reg, 3'b000} +: 8] <= 8'h00;
			end
			if (commit_state_reg == C_DONE) begin
				valid_reg <= VALID_RESET;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (ce && data_take) begin
			cache_mem[load_ptr_reg] <= shift_reg;
		end
	end

	always_comb begin
		page_data = '0;
		for (int b = 0; b < PAGE_BYTES; b++) begin
			page_data[b*8 +: 8] = cache_mem[{page_k_reg, 3'(b)}];
		end
	end

	assign buf_in_word.page = start_page_reg + {6'h00, page_k_reg};
	assign buf_in_word.mask = cur_mask;
	assign buf_in_word.data = page_data;

	always_comb begin
		commit_state_next = commit_state_reg;
		unique case (commit_state_reg)
			C_IDLE: begin
				if (commit_go) begin
					commit_state_next = C_SCAN;
				end
			end
			C_SCAN: begin
				if (page_loaded) begin
					commit_state_next = C_PUSH;
				end else if (page_last) begin
					commit_state_next = C_DONE;
				end
			end
			C_PUSH: begin
				if (push) begin
					commit_state_next = C_WAIT;
				end
			end
			C_WAIT: begin
				if (timer_done) begin
					commit_state_next = page_last ? C_DONE : C_SCAN;
				end
			end
			C_DONE: commit_state_next = C_IDLE;
		endcase
	end

	// page sequencer and write-cycle timer
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			commit_state_reg <= C_IDLE;
			page_k_reg       <= PAGE_FIRST;
			timer_reg        <= TIMER_RESET;
			busy_reg         <= 1'b0;
			standby_reg      <= 1'b1;
			vmon_en_reg      <= 1'b0;
		end else if (ce) begin
			commit_state_reg <= commit_state_next;
			standby_reg      <= standby_next;
			vmon_en_reg      <= ~standby_next;
			busy_reg         <= commit_state_next != C_IDLE;
			if (commit_go) begin
				page_k_reg <= PAGE_FIRST;
			end else if (page_step) begin
				page_k_reg <= page_k_reg + 3'h1;
			end
			if (push) begin
				timer_reg <= TIMER_W'(WRITE_CYCLES);
			end else if (commit_state_reg == C_WAIT) begin
				timer_reg <= timer_reg - TIMER_ONE;
			end
		end
	end

	page_word_buffer page_word_buffer_inst (
		.mclk      (mclk),
		.rstn      (rstn),
		.ce        (ce),
		.in_valid  (push),
		.in_ready  (buf_in_ready),
		.in_word   (buf_in_word),
		.out_valid (array_valid),
		.out_ready (array_ready),
		.out_word  (array_word)
	);

	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn || !ce);

	sda_change_low_a: assert property ($changed(sda_oe_reg) |-> !$past(scl_s))
		else $error("sda drive changed while scl high");
	start_offset_a: assert property (addr_lo_take |=> load_ptr_reg == {3'h0, $past(shift_reg[2:0])})
		else $error("load pointer not at page 0 start offset");
	ptr_wrap_a: assert property (data_take |=> load_ptr_reg == $past(load_ptr_reg) + 6'h01)
		else $error("load pointer did not advance");
	busy_nack_a: assert property (busy_reg && byte_end && bus_state_reg == B_CTRL |=> !sda_oe_reg)
		else $error("address acknowledged during write cycle");
	cs_nack_a: assert property (byte_end && bus_state_reg == B_CTRL
		&& shift_reg[3:1] != pins_s_reg.cs |=> !sda_oe_reg && bus_state_reg == B_IDLE)
		else $error("responded to foreign chip select");
	page_order_a: assert property (commit_state_reg != C_IDLE |=> page_k_reg >= $past(page_k_reg))
		else $error("cache pages committed out of order");
	mask_valid_a: assert property (push |-> buf_in_word.mask != 8'h00 && buf_in_word.mask == valid_reg[8*page_k_reg +: 8])
		else $error("program mask differs from loaded bytes");
	cycle_len_a: assert property (push |=> timer_reg == TIMER_W'(WRITE_CYCLES) ##1 commit_state_reg == C_WAIT)
		else $error("page write cycle length wrong");
	low_block_a: assert property (prog_block && commit_state_reg == C_PUSH |=> commit_state_reg == C_PUSH && timer_reg == $past(timer_reg))
		else $error("programming while voltage low");
	monitor_on_a: assert property (commit_state_reg == C_PUSH |-> vmon_en_reg && !standby_reg)
		else $error("monitor off while programming");
	stop_start_a: assert property ($rose(busy_reg) |-> $past(stop_det))
		else $error("write sequence began without stop");
	clear_done_a: assert property (commit_state_reg == C_DONE |=> valid_reg == VALID_RESET && !busy_reg)
		else $error("valid flags not cleared after commit");
	first_page_a: assert property (commit_go |=> page_k_reg == PAGE_FIRST)
		else $error("commit did not start at cache page 0");

	push_seen_c: cover property (push);
	wrap_seen_c: cover property (data_take && load_ptr_reg == 6'h3f);
	ack_seen_c: cover property (byte_end && bus_state_reg == B_CTRL && ctrl_match);
	stall_seen_c: cover property (commit_state_reg == C_PUSH && !buf_in_ready);
endmodule

// ===== tb/twi_master_model.sv
// two-wire bus master model: start, stop, byte write with acknowledge sample
// assumes a pull-up on sda outside; sda_rel low pulls the line down
`timescale 1ns/1ps
module twi_master_model (
	// bus pins
	output logic      scl,
	output logic      sda_rel,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// one quarter of the 80 ns bus clock
	task automatic step(input logic c, input logic d);
		scl = c;
		sda_rel = d;
		#20;
	endtask
	// sda moves with scl high only here and in stop
	task automatic start();
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask
	task automatic stop();
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask
	// data set while scl low, msb first, ninth clock samples the acknowledge
	task automatic send(input logic [7:0] b, output logic ack);
		logic [8:0] bits;
		bits = {b, 1'b1};
		for (int i = 8; i >= 0; i--) begin
			step(1'b0, bits[i]);
			step(1'b1, bits[i]);
			ack = ~sda;
			step(1'b1, bits[i]);
			step(1'b0, bits[i]);
		end
	endtask
endmodule

// ===== tb/eeprom_page_cache_writer_tb.sv
// self-checking bench for the page cache writer: bus writes, page commits, stalls
// assumes the two-wire master model and a pull-up on sda
`timescale 1ns/1ps
module eeprom_page_cache_writer_tb;
	import eeprom_cache_pkg::*;
	localparam int unsigned WC = 200;
	logic           mclk        = 1'b0;
	logic           rstn        = 1'b0;
	logic           ce          = 1'b1;
	logic [2:0]     cs_pins     = 3'h0;
	logic           low_voltage = 1'b0;
	logic           array_ready = 1'b1;
	logic           scl;
	logic           sda_rel;
	logic           sda_out;
	logic           sda_oe;
	logic           vmon_en;
	logic           array_valid;
	logic           busy;
	logic           standby;
	wire logic      sda = sda_rel & ~(sda_oe & ~sda_out);
	page_write_type array_word;
	page_write_type exp_q[$];
	logic [7:0]     cdata[64];
	logic           cvalid[64] = '{default: 1'b0};
	int             error_cnt = 0;
	int             tests_run = 0;
	int             gap       = WC + 1;
	int             rmode     = 0;

	always #2.5 mclk = ~mclk;

	twi_master_model twi_master_model_inst (.scl(scl), .sda_rel(sda_rel), .sda(sda));

	eeprom_page_cache_writer #(.WRITE_CYCLES(WC)) eeprom_page_cache_writer_inst (
		.mclk(mclk), .rstn(rstn), .ce(ce), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .chip_select_inputs(cs_pins), .low_voltage(low_voltage), .vmon_en(vmon_en),
		.array_valid(array_valid), .array_ready(array_ready), .array_word(array_word), .busy(busy),
		.standby(standby));

	task automatic check(input logic [80:0] seen, input logic [80:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// unmasked bytes carry stale data, so blank them before comparing
	function automatic page_write_type keep(page_write_type w);
		for (int j = 0; j < 8; j++) begin
			if (w.mask[j] !== 1'b1) begin
				w.data[8*j +: 8] = 8'h00;
			end
		end
		return w;
	endfunction

	// expected commit list from the loaded cache bytes
	task automatic plan(input logic [8:0] page);
		page_write_type w;
		for (int k = 0; k < 8; k++) begin
			w = '0;
			w.page = page + 9'(k);
			for (int j = 0; j < 8; j++) begin
				w.mask[j] = cvalid[8*k+j];
				w.data[8*j +: 8] = cdata[8*k+j];
				cvalid[8*k+j] = 1'b0;
			end
			if (w.mask != 8'h00) begin
				exp_q.push_back(keep(w));
			end
		end
	endtask

	always @(negedge mclk) begin
		array_ready <= rmode == 0 ? 1'b1 : rmode == 1 ? 1'($urandom % 2) : 1'b0;
	end

	always @(posedge mclk) begin
		gap++;
		if (array_valid === 1'b1 && array_ready === 1'b1) begin
			check(keep(array_word), exp_q.size() != 0 ? exp_q.pop_front() : '1);
			if (rmode == 0) begin
				check(gap > WC, 1'b1);
			end
			gap = 0;
		end
	end

	task automatic wr(input logic [2:0] csel, input logic [11:0] addr, input int n, input logic exp_ack,
		input logic restart);
		logic       a;
		logic [7:0] b;
		int         idx;
		twi_master_model_inst.start();
		twi_master_model_inst.send({DEV_TYPE_CODE, csel, 1'b0}, a);
		check(a, exp_ack);
		if (a === 1'b1) begin
			twi_master_model_inst.send({4'h0, addr[11:8]}, a);
			twi_master_model_inst.send(addr[7:0], a);
			idx = addr[2:0];
			for (int i = 0; i < n; i++) begin
				b = 8'($urandom);
				twi_master_model_inst.send(b, a);
				check(a, 1'b1);
				cdata[idx] = b;
				cvalid[idx] = 1'b1;
				idx = (idx + 1) % 64;
			end
		end
		if (exp_ack && !restart) begin
			plan(addr[11:3]);
		end
		if (!restart) begin
			twi_master_model_inst.stop();
		end
		repeat (16) @(negedge mclk);
		if (restart) begin
			check(busy, 1'b0);
		end else if (exp_ack && n > 0) begin
			check({busy, vmon_en, standby}, 3'b110);
		end
	endtask

	task automatic settle();
		int t = 0;
		while ((busy !== 1'b0 || exp_q.size() != 0) && t < 20000) begin
			@(negedge mclk);
			t++;
		end
		@(negedge mclk);
		check(t < 20000, 1'b1);
		check({standby, vmon_en, sda_out, busy}, 4'b1000);
	endtask

	initial begin
		#400_000;
		error_cnt++;
		summarize();
	end

	initial begin
		void'($urandom(32'hc772));
		cs_pins = 3'($urandom);
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		rstn = 1'b1;
		repeat (4) @(negedge mclk);
		check({standby, vmon_en, sda_oe, array_valid, busy}, 5'b10000);
		// full cache from offset 2, then a poll while committing
		wr(cs_pins, 12'h01a, 64, 1'b1, 1'b0);
		wr(cs_pins, 12'h01a, 0, 1'b0, 1'b0);
		settle();
		wr(cs_pins, 12'h3fd, 3, 1'b1, 1'b0);
		// clock enable low freezes the running write cycle
		ce = 1'b0;
		repeat (50) @(negedge mclk);
		check({busy, standby, array_valid}, 3'b100);
		ce = 1'b1;
		settle();
		wr(cs_pins, 12'h200, 70, 1'b1, 1'b0);
		settle();
		wr(cs_pins ^ 3'h4, 12'h100, 4, 1'b0, 1'b0);
		settle();
		wr(cs_pins, 12'h040, 0, 1'b1, 1'b0);
		settle();
		wr(cs_pins, 12'h155, 5, 1'b1, 1'b1);
		wr(cs_pins, 12'h15e, 4, 1'b1, 1'b0);
		settle();
		// low supply holds the commit back
		low_voltage = 1'b1;
		wr(cs_pins, 12'h0f1, 10, 1'b1, 1'b0);
		repeat (100) @(negedge mclk);
		check(array_valid, 1'b0);
		low_voltage = 1'b0;
		settle();
		// array stalls long enough to fill the buffer
		rmode = 2;
		wr(cs_pins, 12'h7c2, 64, 1'b1, 1'b0);
		repeat (3 * WC) @(negedge mclk);
		rmode = 1;
		settle();
		for (int r = 0; r < 4; r++) begin
			wr(cs_pins, 12'($urandom), int'(1 + $urandom % 24), 1'b1, 1'b0);
			settle();
		end
		summarize();
	end
endmodule
